// ---- rtl/fcd_pkg.sv ----
// Shared constants, register map and carriers of the floppy command decoder.
// Assumes a single 50 MHz clock and an APB master with 32-bit data.
package fcd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and times
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned STEP_NORM_US[4] = '{3000, 6000, 10000, 15000};
	localparam int unsigned STEP_TEST_US[4] = '{184, 190, 198, 208};
	localparam int unsigned E_DELAY_US      = 15000;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFF_CMD      = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_TRACK    = 8'h08;
	localparam logic [7:0] OFF_TARGET   = 8'h0c;
	localparam logic [7:0] OFF_CTRL     = 8'h10;
	localparam logic [7:0] OFF_INT_STAT = 8'h14;
	localparam logic [7:0] OFF_INT_MASK = 8'h18;
	localparam logic [7:0] OFF_FIELDS   = 8'h1c;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned CTRL_TEST_BIT = 0;
	localparam int unsigned CTRL_SLOW_BIT = 1;
	localparam int unsigned INT_DONE_BIT  = 0;
	localparam int unsigned INT_FI_BIT    = 1;
	localparam int unsigned INT_ERR_BIT   = 2;
	localparam int unsigned INT_REF_BIT   = 3;
	localparam int unsigned INT_W         = 4;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and marks
	localparam logic [7:0]       TRACK_RST  = 8'h00;
	localparam logic [7:0]       TARGET_RST = 8'h00;
	localparam logic [1:0]       CTRL_RST   = 2'h1;
	localparam logic [INT_W-1:0] MASK_RST   = 4'h0;
	localparam logic [7:0]       CMD_RST    = 8'h00;
	localparam logic [7:0]       DAM_NORMAL  = 8'hfb;
	localparam logic [7:0]       DAM_DELETED = 8'hf8;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef enum logic [3:0] {
		FCD_RESTORE,
		FCD_SEEK,
		FCD_STEP,
		FCD_STEP_IN,
		FCD_STEP_OUT,
		FCD_READ_SECTOR,
		FCD_WRITE_SECTOR,
		FCD_READ_ADDRESS,
		FCD_READ_TRACK,
		FCD_WRITE_TRACK,
		FCD_FORCE_INT,
		FCD_ILLEGAL
	} fcd_cmd_t;

	typedef struct packed {
		logic       head_load;
		logic       verify;
		logic [1:0] step_rate_field;
		logic       update;
		logic       multi;
		logic       side;
		logic       delay_e;
		logic       side_cmp;
		logic       dam_deleted;
		logic [3:0] fi_cond;
	} fcd_fields_t;

	typedef struct packed {
		logic [3:0] kind;
		logic       imm_hold;
		logic       not_ready;
		logic       side_mismatch;
		logic       seek_error;
		logic       drive_ready;
		logic       head_load;
		logic       irq_out;
		logic       busy;
	} fcd_status_t;

endpackage

// ---- rtl/fcd_timer.sv ----
// Down counter that pulses expired a loaded number of cycles after load.
// Assumes load values of one or more; abort stops a running count.
`timescale 1ns/1ps
module fcd_timer #(
	parameter int unsigned W = 24
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic         abort,
	input  wire logic [W-1:0] value,
	output logic              expired
);

	logic [W-1:0] cnt;
	logic         running;

	generate
		if (W < 2) begin : g_bad_width
			$error("fcd_timer width too small");
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt     <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (abort) begin
				running <= 1'b0;
			end else if (load) begin
				cnt     <= value;
				running <= 1'b1;
			end else if (running) begin
				if (cnt <= W'(1)) begin
					expired <= 1'b1;
					running <= 1'b0;
				end else begin
					cnt <= cnt - W'(1);
				end
			end
		end
	end

endmodule

// ---- rtl/fcd_core.sv ----
// Floppy command decoder: APB registers, command decode, positioning,
// delay, header check and forced interrupt logic.
// Assumes synchronous drive inputs; header_valid, op_done are pulses.
//
// Function
// R01 - The command byte's upper bits select one of eleven commands, taken in true polarity.
// R02 - On a positioning command bit 3 loads the head when one and unloads it when zero.
// R03 - On a positioning command bit 2 asks for a track check after positioning.
// R04 - Bits 1-0 of a positioning command pick a step interval from the clock and test choice.
// R05 - Bit 4 of step, step in and step out lets each step update the track register.
// R06 - Bit 4 of a sector command picks one record or several consecutive records.
// R07 - Bit 0 of a sector write picks the normal mark fb or the deleted mark f8.
// R08 - The E flag of sector and track commands inserts a 15 ms delay before execution; with the CTRL slow bit set the code waits 30 ms.
// R09 - With compare on, the S bit is the side expected in the sector header.
// R10 - The C flag of a sector command turns the side comparison on or off.
// R11 - Bits 3-0 of the forced interrupt are four separate interrupt conditions.
// R12 - Condition bit 0 raises the interrupt line when the drive goes from not ready to ready.
// R13 - A forced interrupt with no condition bit ends the running command without interrupt.
// R14 - Any forced interrupt ends the running command at once and clears busy.
// R15 - An immediate interrupt survives status reads and command writes until a zero one.
// R16 - Several condition bits act as an OR: the first condition met raises the line.
`timescale 1ns/1ps
module fcd_core
	import fcd_pkg::*;
#(
	parameter int unsigned TIMER_W         = 24,
	parameter int unsigned STEP_NORM_CYC[4] = '{STEP_NORM_US[0] * CLK_MHZ,
		STEP_NORM_US[1] * CLK_MHZ, STEP_NORM_US[2] * CLK_MHZ, STEP_NORM_US[3] * CLK_MHZ},
	parameter int unsigned STEP_TEST_CYC[4] = '{STEP_TEST_US[0] * CLK_MHZ,
		STEP_TEST_US[1] * CLK_MHZ, STEP_TEST_US[2] * CLK_MHZ, STEP_TEST_US[3] * CLK_MHZ},
	parameter int unsigned E_DELAY_CYC      = E_DELAY_US * CLK_MHZ
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        drive_ready,
	input  wire logic        index_pulse,
	input  wire logic        header_valid,
	input  wire logic [7:0]  header_track,
	input  wire logic        header_side,
	input  wire logic        op_done,
	output logic             irq,
	output logic             irq_out,
	output logic             busy,
	output logic             head_load,
	output logic             step_pulse,
	output logic             step_dir,
	output logic             verify_start,
	output logic             xfer_start,
	output fcd_fields_t      cmd_fields,
	output logic [7:0]       dam_byte
);

	typedef enum {ST_IDLE, ST_POS, ST_STEP, ST_DELAY, ST_HEADER, ST_XFER} fcd_state_t;

	fcd_state_t            state;
	fcd_cmd_t              kind;
	fcd_cmd_t              new_kind;
	fcd_fields_t           new_fields;
	fcd_status_t           status;
	logic [7:0]            cmd_reg;
	logic [7:0]            track;
	logic [7:0]            target;
	logic [1:0]            ctrl;
	logic [INT_W-1:0]      int_stat;
	logic [INT_W-1:0]      int_mask;
	logic [INT_W-1:0]      int_ev;
	logic [INT_W-1:0]      next_int_stat;
	logic [3:0]            fi_cond;
	logic [31:0]           read_mux;
	logic [31:0]           step_base;
	logic [TIMER_W-1:0]    step_cycles;
	logic [TIMER_W-1:0]    e_cycles;
	logic [TIMER_W-1:0]    timer_val;
	logic                  timer_load;
	logic                  timer_expired;
	logic                  access;
	logic                  done_acc;
	logic                  hit;
	logic                  wr_en;
	logic                  rd_en;
	logic                  cmd_wr;
	logic                  fi;
	logic                  start;
	logic                  refused;
	logic                  ready_q;
	logic                  index_q;
	logic                  ready_rise;
	logic                  ready_fall;
	logic                  index_rise;
	logic                  fi_set;
	logic                  imm_hold;
	logic                  clear_req;
	logic                  stepped;
	logic                  need_step;
	logic                  dir;
	logic                  upd;
	logic                  done_ev;
	logic                  err_ev;
	logic                  not_ready;
	logic                  seek_err;
	logic                  side_mis;

	generate
		if (64'(2) * 64'(STEP_NORM_CYC[3]) >= (64'(1) << TIMER_W)
			|| 64'(2) * 64'(E_DELAY_CYC) >= (64'(1) << TIMER_W)) begin : g_bad_timer
			$error("fcd_core TIMER_W too narrow for the longest interval");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	function automatic fcd_cmd_t decode_cmd(input logic [7:0] c);
		unique casez (c[7:3])
			5'b0000?: decode_cmd = FCD_RESTORE; // R01
			5'b0001?: decode_cmd = FCD_SEEK; // R01
			5'b001??: decode_cmd = FCD_STEP; // R01
			5'b010??: decode_cmd = FCD_STEP_IN; // R01
			5'b011??: decode_cmd = FCD_STEP_OUT; // R01
			5'b100??: decode_cmd = FCD_READ_SECTOR; // R01
			5'b101??: decode_cmd = FCD_WRITE_SECTOR; // R01
			5'b11000: decode_cmd = FCD_READ_ADDRESS; // R01
			5'b1101?: decode_cmd = FCD_FORCE_INT; // R01
			5'b11100: decode_cmd = FCD_READ_TRACK; // R01
			5'b11110: decode_cmd = FCD_WRITE_TRACK; // R01
			default:  decode_cmd = FCD_ILLEGAL;
		endcase
	endfunction

	function automatic logic is_pos(input fcd_cmd_t k);
		is_pos = k inside {FCD_RESTORE, FCD_SEEK, FCD_STEP, FCD_STEP_IN, FCD_STEP_OUT};
	endfunction

	function automatic logic is_sector(input fcd_cmd_t k);
		is_sector = k inside {FCD_READ_SECTOR, FCD_WRITE_SECTOR};
	endfunction

	always_comb begin
		new_kind                   = decode_cmd(pwdata[7:0]);
		new_fields.head_load       = pwdata[3]; // R02
		new_fields.verify          = pwdata[2]; // R03
		new_fields.step_rate_field = pwdata[1:0]; // R04
		new_fields.update          = pwdata[4]; // R05
		new_fields.multi           = pwdata[4]; // R06
		new_fields.side            = pwdata[3]; // R09
		new_fields.delay_e         = pwdata[2]; // R08
		new_fields.side_cmp        = pwdata[1]; // R10
		new_fields.dam_deleted     = pwdata[0]; // R07
		new_fields.fi_cond         = pwdata[3:0]; // R11
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: two-cycle access, pready from a flop

	assign access   = psel & penable;
	assign done_acc = access & pready;
	assign hit      = (paddr[1:0] == 2'b00) && (paddr <= OFF_FIELDS);
	assign wr_en    = done_acc & pwrite & hit;
	assign rd_en    = done_acc & ~pwrite & hit;
	assign cmd_wr   = wr_en && (paddr == OFF_CMD);
	assign fi       = cmd_wr && (new_kind == FCD_FORCE_INT);
	assign start    = cmd_wr && !busy && !fi && (new_kind != FCD_ILLEGAL);
	assign refused  = cmd_wr && !fi && (busy || new_kind == FCD_ILLEGAL);

	always_comb begin
		status.kind          = kind;
		status.imm_hold      = imm_hold;
		status.not_ready     = not_ready;
		status.side_mismatch = side_mis;
		status.seek_error    = seek_err;
		status.drive_ready   = drive_ready;
		status.head_load     = head_load;
		status.irq_out       = irq_out;
		status.busy          = busy;
		unique case (paddr)
			OFF_CMD:      read_mux = {24'h000000, cmd_reg};
			OFF_STATUS:   read_mux = 32'(status);
			OFF_TRACK:    read_mux = {24'h000000, track};
			OFF_TARGET:   read_mux = {24'h000000, target};
			OFF_CTRL:     read_mux = {30'h00000000, ctrl};
			OFF_INT_STAT: read_mux = {28'h0000000, int_stat};
			OFF_INT_MASK: read_mux = {28'h0000000, int_mask};
			OFF_FIELDS:   read_mux = 32'(cmd_fields);
			default:      read_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~hit;
			prdata  <= pwrite ? 32'h00000000 : read_mux;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			target   <= TARGET_RST;
			ctrl     <= CTRL_RST;
			int_mask <= MASK_RST;
		end else if (wr_en) begin
			if (paddr == OFF_TARGET)
				target <= pwdata[7:0];
			if (paddr == OFF_CTRL)
				ctrl <= pwdata[1:0];
			if (paddr == OFF_INT_MASK)
				int_mask <= pwdata[INT_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_reg    <= CMD_RST;
			kind       <= FCD_RESTORE;
			cmd_fields <= '0;
		end else if (start || fi) begin
			cmd_reg    <= pwdata[7:0];
			kind       <= new_kind;
			cmd_fields <= new_fields;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step interval and delay

	always_comb begin
		step_base = ctrl[CTRL_TEST_BIT] ? STEP_NORM_CYC[cmd_fields.step_rate_field]
			: STEP_TEST_CYC[cmd_fields.step_rate_field]; // R04
		step_cycles = ctrl[CTRL_SLOW_BIT] ? TIMER_W'(step_base << 1)
			: TIMER_W'(step_base); // R04
		e_cycles = ctrl[CTRL_SLOW_BIT] ? TIMER_W'(E_DELAY_CYC << 1) : TIMER_W'(E_DELAY_CYC);
	end

	fcd_timer #(
		.W(TIMER_W)
	) u_timer (
		.clock  (clock),
		.rst    (rst),
		.load   (timer_load),
		.abort  (fi),
		.value  (timer_val),
		.expired(timer_expired)
	);

	always_comb begin
		unique case (kind)
			FCD_RESTORE: begin
				need_step = track != 8'h00;
				dir       = 1'b0;
				upd       = 1'b1;
			end
			FCD_SEEK: begin
				need_step = track != target;
				dir       = target > track;
				upd       = 1'b1;
			end
			FCD_STEP_IN: begin
				need_step = !stepped;
				dir       = 1'b1;
				upd       = cmd_fields.update; // R05
			end
			FCD_STEP_OUT: begin
				need_step = !stepped;
				dir       = 1'b0;
				upd       = cmd_fields.update; // R05
			end
			default: begin
				need_step = !stepped;
				dir       = step_dir;
				upd       = cmd_fields.update; // R05
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer

	always_ff @(posedge clock) begin
		if (rst) begin
			state        <= ST_IDLE;
			busy         <= 1'b0;
			head_load    <= 1'b0;
			step_pulse   <= 1'b0;
			step_dir     <= 1'b0;
			verify_start <= 1'b0;
			xfer_start   <= 1'b0;
			track        <= TRACK_RST;
			timer_load   <= 1'b0;
			timer_val    <= '0;
			stepped      <= 1'b0;
			done_ev      <= 1'b0;
			err_ev       <= 1'b0;
			not_ready    <= 1'b0;
			seek_err     <= 1'b0;
			side_mis     <= 1'b0;
			dam_byte     <= DAM_NORMAL;
		end else begin
			step_pulse   <= 1'b0;
			verify_start <= 1'b0;
			xfer_start   <= 1'b0;
			timer_load   <= 1'b0;
			done_ev      <= 1'b0;
			err_ev       <= 1'b0;
			if (fi) begin
				state <= ST_IDLE; // R14 R13
				busy  <= 1'b0; // R14
			end else begin
				unique case (state)
					ST_IDLE: begin
						if (wr_en && paddr == OFF_TRACK) begin
							track <= pwdata[7:0];
						end else if (start) begin
							busy      <= 1'b1;
							stepped   <= 1'b0;
							not_ready <= 1'b0;
							seek_err  <= 1'b0;
							side_mis  <= 1'b0;
							dam_byte  <= pwdata[0] ? DAM_DELETED : DAM_NORMAL; // R07
							if (is_pos(new_kind)) begin
								head_load <= pwdata[3]; // R02
								state     <= ST_POS;
							end else if (!drive_ready) begin
								not_ready <= 1'b1;
								busy      <= 1'b0;
								done_ev   <= 1'b1;
							end else begin
								head_load <= 1'b1;
								if (pwdata[2]) begin
									timer_val  <= e_cycles; // R08
									timer_load <= 1'b1; // R08
									state      <= ST_DELAY;
								end else begin
									state      <= is_sector(new_kind) ? ST_HEADER : ST_XFER;
									xfer_start <= !is_sector(new_kind);
								end
							end
						end
					end
					ST_POS: begin
						if (need_step) begin
							step_pulse <= 1'b1;
							step_dir   <= dir;
							stepped    <= 1'b1;
							if (upd)
								track <= dir ? track + 8'h01 : track - 8'h01; // R05
							timer_val  <= step_cycles; // R04
							timer_load <= 1'b1;
							state      <= ST_STEP;
						end else if (cmd_fields.verify) begin
							verify_start <= 1'b1; // R03
							state        <= ST_HEADER;
						end else begin
							busy    <= 1'b0; // R03
							done_ev <= 1'b1;
							state   <= ST_IDLE;
						end
					end
					ST_STEP: begin
						if (timer_expired)
							state <= ST_POS;
					end
					ST_DELAY: begin
						if (timer_expired) begin
							state      <= is_sector(kind) ? ST_HEADER : ST_XFER; // R08
							xfer_start <= !is_sector(kind);
						end
					end
					ST_HEADER: begin
						if (header_valid) begin
							if (is_pos(kind)) begin
								seek_err <= header_track != track;
								err_ev   <= header_track != track;
								busy     <= 1'b0;
								done_ev  <= 1'b1;
								state    <= ST_IDLE;
							end else if (cmd_fields.side_cmp && header_side != cmd_fields.side) begin
								side_mis <= 1'b1; // R09 R10
								err_ev   <= 1'b1;
								busy     <= 1'b0;
								done_ev  <= 1'b1;
								state    <= ST_IDLE;
							end else begin
								xfer_start <= 1'b1;
								state      <= ST_XFER;
							end
						end
					end
					ST_XFER: begin
						if (op_done) begin
							if (is_sector(kind) && cmd_fields.multi) begin
								state <= ST_HEADER; // R06
							end else begin
								busy    <= 1'b0; // R06
								done_ev <= 1'b1;
								state   <= ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Forced interrupt conditions and interrupt line

	assign ready_rise = drive_ready & ~ready_q;
	assign ready_fall = ~drive_ready & ready_q;
	assign index_rise = index_pulse & ~index_q;
	assign fi_set     = (fi_cond[0] & ready_rise) // R12
		| (fi_cond[1] & ready_fall) | (fi_cond[2] & index_rise); // R11 R16
	assign clear_req  = cmd_wr || (rd_en && paddr == OFF_STATUS);

	always_ff @(posedge clock) begin
		if (rst) begin
			ready_q <= drive_ready;
			index_q <= 1'b0;
			fi_cond <= 4'h0;
		end else begin
			ready_q <= drive_ready;
			index_q <= index_pulse;
			if (fi)
				fi_cond <= pwdata[3:0]; // R11
			else if (start)
				fi_cond <= 4'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			imm_hold <= 1'b0;
		else if (fi)
			imm_hold <= pwdata[3] | (imm_hold & |pwdata[2:0]); // R15
	end

	always_ff @(posedge clock) begin
		if (rst)
			irq_out <= 1'b0;
		else if ((fi && pwdata[3]) || fi_set || done_ev)
			irq_out <= 1'b1; // R11 R16
		else if (fi && pwdata[3:0] == 4'h0)
			irq_out <= 1'b0; // R13 R15
		else if (clear_req && !imm_hold)
			irq_out <= 1'b0; // R15
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky event bits, write one to clear, set wins

	always_comb begin
		int_ev                = '0;
		int_ev[INT_DONE_BIT]  = done_ev;
		int_ev[INT_FI_BIT]    = fi_set || (fi && pwdata[3]);
		int_ev[INT_ERR_BIT]   = err_ev;
		int_ev[INT_REF_BIT]   = refused;
		next_int_stat         = int_stat;
		if (wr_en && paddr == OFF_INT_STAT)
			next_int_stat = int_stat & ~pwdata[INT_W-1:0];
		next_int_stat = next_int_stat | int_ev;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			int_stat <= '0;
			irq      <= 1'b0;
		end else begin
			int_stat <= next_int_stat;
			irq      <= |(next_int_stat & int_mask);
		end
	end

endmodule

// ---- verif/fcd_assertions.sv ----
// Checker of command start, flag decode and interrupt line of fcd_core.
// Bound to fcd_core; sees its ports only, one clock domain.
`timescale 1ns/1ps
module fcd_assertions
	import fcd_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        busy,
	input wire logic        irq_out,
	input wire fcd_fields_t cmd_fields,
	input wire logic [7:0]  dam_byte
);
	logic wr_cmd;
	logic imm;
	assign wr_cmd = psel & penable & pready & pwrite & (paddr == OFF_CMD);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Immediate condition outstanding until a zero forced interrupt
	always_ff @(posedge clock) begin
		if (rst)
			imm <= 1'b0;
		else if (wr_cmd && pwdata[7:4] == 4'hd)
			imm <= pwdata[3] | (imm & (pwdata[3:0] != 4'h0));
	end
	sequence s_fi;
		wr_cmd && pwdata[7:4] == 4'hd;
	endsequence
	sequence s_go;
		wr_cmd && !busy && pwdata[7:4] != 4'hd && !(pwdata[7:6] == 2'b11 && pwdata[3]);
	endsequence
	AST_FI_BUSY: assert property (s_fi |=> !busy)
		else $error("busy stayed high after forced interrupt");
	AST_IMM_SET: assert property ((s_fi ##0 pwdata[3]) |=> irq_out)
		else $error("immediate condition gave no interrupt");
	AST_IMM_HOLD: assert property (imm |-> irq_out)
		else $error("immediate interrupt dropped early");
	AST_START: assert property (s_go |=> busy)
		else $error("legal command did not start");
	AST_TYPE1: assert property ((s_go ##0 !pwdata[7]) |=>
		cmd_fields.head_load == $past(pwdata[3]) && cmd_fields.verify == $past(pwdata[2])
		&& cmd_fields.step_rate_field == $past(pwdata[1:0]))
		else $error("positioning flags wrong");
	AST_UPDATE: assert property ((s_go ##0 (!pwdata[7] && pwdata[6:5] != 2'b00)) |=>
		cmd_fields.update == $past(pwdata[4]))
		else $error("update flag wrong");
	AST_SECTOR: assert property ((s_go ##0 (pwdata[7:6] == 2'b10)) |=>
		cmd_fields.multi == $past(pwdata[4]) && cmd_fields.side == $past(pwdata[3])
		&& cmd_fields.delay_e == $past(pwdata[2]) && cmd_fields.side_cmp == $past(pwdata[1]))
		else $error("sector flags wrong");
	AST_DAM: assert property ((s_go ##0 (pwdata[7:5] == 3'b101)) |-> ##2
		dam_byte == ($past(pwdata[0], 2) ? DAM_DELETED : DAM_NORMAL))
		else $error("data mark wrong");
	AST_FI_COND: assert property (s_fi |=> cmd_fields.fi_cond == $past(pwdata[3:0]))
		else $error("interrupt conditions wrong");
endmodule
bind fcd_core fcd_assertions u_chk (.clock, .rst, .psel, .penable, .pwrite, .pready, .paddr,
	.pwdata, .busy, .irq_out, .cmd_fields, .dam_byte);

// ---- verif/fcd_drive_model.sv ----
// Drive model: ready level, index, headers each 16 cycles, record transfers.
// Assumes the decoder's clock; headers carry the model's own track count.
`timescale 1ns/1ps
module fcd_drive_model #(
	parameter int unsigned LAT = 5
) (
	input  wire logic  clock,
	input  wire logic  rst,
	input  wire logic  ready_ctl,
	input  wire logic  side_ctl,
	input  wire logic  step_pulse,
	input  wire logic  step_dir,
	input  wire logic  xfer_start,
	output logic       drive_ready,
	output logic       index_pulse,
	output logic       header_valid,
	output logic [7:0] header_track,
	output logic       header_side,
	output logic       op_done
);
	logic [5:0] turn;
	logic [7:0] trk;
	logic [7:0] wait_cnt;
	always_ff @(posedge clock) begin
		if (rst) begin
			turn <= 6'h00;
			trk <= 8'h00;
			wait_cnt <= 8'h00;
		end else begin
			turn <= turn + 6'h01;
			if (step_pulse && step_dir)
				trk <= trk + 8'h01;
			else if (step_pulse && trk != 8'h00)
				trk <= trk - 8'h01;
			if (xfer_start)
				wait_cnt <= 8'(LAT);
			else if (wait_cnt != 8'h00)
				wait_cnt <= wait_cnt - 8'h01;
		end
	end
	// Header fields meaningless outside the valid cycle
	assign drive_ready = ready_ctl;
	assign index_pulse = turn[5:3] == 3'h0;
	assign header_valid = turn[3:0] == 4'h9;
	assign header_track = header_valid ? trk : ~trk;
	assign header_side = header_valid ? side_ctl : ~side_ctl;
	assign op_done = wait_cnt == 8'h01;
endmodule

// ---- verif/tb.sv ----
// Self-checking bench of the floppy command decoder over APB.
// Assumes fcd_drive_model answers headers and transfers.
`timescale 1ns/1ps
module tb import fcd_pkg::*;;
	typedef struct packed {
		logic [7:0]  c;
		logic [3:0]  k;
		logic [13:0] m;
		logic [13:0] v;
	} fcd_row_t;
	localparam int unsigned SN[4] = '{20, 30, 40, 50};
	localparam fcd_row_t ROWS[11] = '{'{8'h0b, 4'h0, 14'h3c00, 14'h2c00},
		'{8'h14, 4'h1, 14'h3c00, 14'h1000}, '{8'h31, 4'h2, 14'h3e00, 14'h0600},
		'{8'h5a, 4'h3, 14'h3e00, 14'h2a00}, '{8'h66, 4'h4, 14'h3e00, 14'h1800},
		'{8'h9e, 4'h5, 14'h01f0, 14'h01e0}, '{8'ha1, 4'h6, 14'h01f0, 14'h0010},
		'{8'hc4, 4'h7, 14'h0040, 14'h0040}, '{8'he0, 4'h8, 14'h0040, 14'h0000},
		'{8'hf4, 4'h9, 14'h0040, 14'h0040}, '{8'hd5, 4'ha, 14'h000f, 14'h0005}};
	logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, header_track, dam_byte;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, irq, irq_out, busy, head_load, step_pulse, step_dir;
	logic        xfer_start, drive_ready, index_pulse, header_valid, header_side, op_done;
	logic        ready_ctl = 1'b1, side_ctl = 1'b1;
	fcd_fields_t cmd_fields;
	int          miscompares = 0, check_count = 0, cycles = 0, n;
	fcd_core #(.STEP_NORM_CYC(SN), .STEP_TEST_CYC('{4, 5, 6, 7}), .E_DELAY_CYC(16)) dut (
		.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.drive_ready, .index_pulse, .header_valid, .header_track, .header_side, .op_done,
		.irq, .irq_out, .busy, .head_load, .step_pulse, .step_dir, .verify_start(),
		.xfer_start, .cmd_fields, .dam_byte);
	fcd_drive_model model (.clock, .rst, .ready_ctl, .side_ctl, .step_pulse, .step_dir,
		.xfer_start, .drive_ready, .index_pulse, .header_valid, .header_track, .header_side,
		.op_done);
	////////////////////////////////////////////////////////////////
	always #10 clock = ~clock;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle;
		@(posedge clock);
		while (busy !== 1'b0)
			@(posedge clock);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		chk(dam_byte, DAM_NORMAL);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, {30'h0, CTRL_RST});
		apb(1'b0, 8'h20, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			apb(1'b1, OFF_CMD, {24'h0, ROWS[i].c});
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd[11:8], ROWS[i].k);
			apb(1'b0, OFF_FIELDS, 32'h0);
			chk(rd[13:0] & ROWS[i].m, ROWS[i].v);
			apb(1'b1, OFF_CMD, 32'hd0);
			@(posedge clock);
			chk(busy, 1'b0);
		end
		$display("test decode table done");
		apb(1'b1, OFF_TRACK, 32'h5);
		apb(1'b1, OFF_CMD, 32'h58);
		wait_idle();
		chk(head_load, 1'b1);
		apb(1'b1, OFF_CMD, 32'h40);
		wait_idle();
		chk(head_load, 1'b0);
		apb(1'b0, OFF_TRACK, 32'h0);
		chk(rd, 32'h6);
		$display("test update done");
		apb(1'b1, OFF_INT_STAT, 32'hf);
		apb(1'b1, OFF_TARGET, 32'h3);
		apb(1'b1, OFF_CMD, 32'h19);
		while (step_pulse !== 1'b1)
			@(posedge clock);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (step_pulse !== 1'b1);
		chk(n, SN[1] + 3);
		chk(step_dir, 1'b0);
		wait_idle();
		apb(1'b0, OFF_TRACK, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, OFF_INT_STAT, 32'h0);
		chk(rd[INT_DONE_BIT], 1'b1);
		chk(irq, 1'b0);
		apb(1'b1, OFF_INT_MASK, 32'h1);
		repeat (2) @(posedge clock);
		chk(irq, 1'b1);
		apb(1'b1, OFF_INT_STAT, 32'h1);
		repeat (2) @(posedge clock);
		chk(irq, 1'b0);
		$display("test seek and interrupt done");
		ready_ctl <= 1'b0;
		apb(1'b1, OFF_CMD, 32'hd1);
		repeat (3) @(posedge clock);
		chk(irq_out, 1'b0);
		ready_ctl <= 1'b1;
		repeat (4) @(posedge clock);
		chk(irq_out, 1'b1);
		apb(1'b1, OFF_CMD, 32'hd0);
		repeat (2) @(posedge clock);
		chk(irq_out, 1'b0);
		$display("test ready rise done");
		apb(1'b1, OFF_CMD, 32'hd8);
		@(posedge clock);
		chk(irq_out, 1'b1);
		apb(1'b0, OFF_STATUS, 32'h0);
		@(posedge clock);
		chk(irq_out, 1'b1);
		apb(1'b1, OFF_CMD, 32'hd0);
		repeat (2) @(posedge clock);
		chk(irq_out, 1'b0);
		$display("test immediate done");
		apb(1'b1, OFF_CMD, 32'hd6);
		ready_ctl <= 1'b0;
		repeat (4) @(posedge clock);
		chk(irq_out, 1'b1);
		ready_ctl <= 1'b1;
		apb(1'b1, OFF_CMD, 32'hd0);
		$display("test either condition done");
		conclude();
	end
endmodule
